//--- rtl/mpp_mac_end.sv
// Controller end of the port: register port toward software, pins toward the device
`timescale 1ns/1ps
module mpp_mac_end
	import mpp_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	mpp_mii_if.mac mii,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic irq_o
);
	// Pins from the device pass two flops: clocks, rx word, col, crs
	localparam int SW = XW + 4;
	logic [SW-1:0] meta_ff;
	logic [SW-1:0] sync_ff;
	logic txc_d_ff;
	logic rxc_d_ff;
	logic col_d_ff;
	logic crs_d_ff;
	logic [XW-1:0] pend_ff;
	logic pend_v_ff;
	logic [XW-1:0] txo_ff;
	logic [XW-1:0] rxw_ff;
	logic [IRQ_W-1:0] istat_ff;
	logic [IRQ_W-1:0] imask_ff;
	logic [31:0] rdata_ff;
	logic irq_ff;
	logic [DIV_W-1:0] mdc_div_ff;
	logic mdc_ff;

	// Named decodes
	wire txc_s = sync_ff[XW];
	wire rxc_s = sync_ff[XW+1];
	wire col_s = sync_ff[XW+2];
	wire crs_s = sync_ff[XW+3];
	wire tx_rise = txc_s & ~txc_d_ff;
	wire rx_rise = rxc_s & ~rxc_d_ff;
	wire wr_tx = wr_i & (addr_i == REG_TX);
	wire wr_istat = wr_i & (addr_i == REG_ISTAT);
	wire wr_imask = wr_i & (addr_i == REG_IMASK);
	wire rx_valid_s = sync_ff[TXF_EN_BIT];
	wire rx_fault_s = sync_ff[TXF_FAULT_BIT];
	wire [IRQ_W-1:0] ev = {crs_s & ~crs_d_ff, col_s & ~col_d_ff,
		rx_rise & rx_fault_s, rx_rise & rx_valid_s};
	wire [IRQ_W-1:0] clr = wr_istat ? wdata_i[IRQ_W-1:0] : 4'h0;
	wire [31:0] stat_w = {29'h0, col_s, crs_s, pend_v_ff};
	wire [31:0] rd_mux = (addr_i == REG_RX) ? {26'h0, rxw_ff} :
		(addr_i == REG_STAT) ? stat_w :
		(addr_i == REG_ISTAT) ? {28'h0, istat_ff} :
		(addr_i == REG_IMASK) ? {28'h0, imask_ff} :
		(addr_i == REG_TX) ? {26'h0, pend_ff} : 32'h0;

	// Synchroniser; only the second stage is looked at
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= {mii.carrier_sense_flag, mii.collision_flag, mii.phy_rx_clock,
				mii.phy_tx_clock, mii.phy_rx_valid, mii.phy_rx_fault, mii.phy_rx_nibble};
			sync_ff <= meta_ff;
		end
	end

	// Edge history for clocks and flags
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			txc_d_ff <= 1'b0;
			rxc_d_ff <= 1'b0;
			col_d_ff <= 1'b0;
			crs_d_ff <= 1'b0;
		end else begin
			txc_d_ff <= txc_s;
			rxc_d_ff <= rxc_s;
			col_d_ff <= col_s;
			crs_d_ff <= crs_s;
		end
	end

	// One pending word; a new write overwrites it if not yet sent
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend_ff <= '0;
			pend_v_ff <= 1'b0;
		end else if (wr_tx) begin
			pend_ff <= wdata_i[XW-1:0];
			pend_v_ff <= 1'b1;
		end else if (tx_rise) begin
			pend_v_ff <= 1'b0;
		end
	end

	// Pins change only just after the device clock rises, enable with data
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			txo_ff <= '0;
		end else if (tx_rise) begin
			txo_ff <= pend_v_ff ? pend_ff : '0;
		end
	end

	// Receive word taken on the rising receive clock
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rxw_ff <= '0;
		end else if (rx_rise) begin
			rxw_ff <= sync_ff[XW-1:0];
		end
	end

	// Sticky status, set wins over a write-one clear
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			istat_ff <= IRQ_RST;
			imask_ff <= IRQ_RST;
			irq_ff <= 1'b0;
			rdata_ff <= 32'h0;
		end else begin
			istat_ff <= (istat_ff & ~clr) | ev;
			if (wr_imask) begin
				imask_ff <= wdata_i[IRQ_W-1:0];
			end
			irq_ff <= |(((istat_ff & ~clr) | ev) & imask_ff);
			rdata_ff <= rd_i ? rd_mux : 32'h0;
		end
	end

	// Management clock divider keeps the rate at or below the limit
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mdc_div_ff <= DIV_RST;
			mdc_ff <= 1'b0;
		end else if (mdc_div_ff == DIV_RST) begin
			mdc_div_ff <= MDC_HALF_C;
			mdc_ff <= ~mdc_ff;
		end else begin
			mdc_div_ff <= mdc_div_ff - 4'h1;
		end
	end

	assign mii.mac_tx_nibble = txo_ff[3:0];
	assign mii.mac_tx_fault_in = txo_ff[TXF_FAULT_BIT];
	assign mii.mac_tx_valid = txo_ff[TXF_EN_BIT];
	assign mii.mgmt_serial_clock = mdc_ff;
	assign mii.mdio_mac_o = 1'b0;
	assign mii.mdio_mac_oe = 1'b0;
	assign rdata_o = rdata_ff;
	assign irq_o = irq_ff;
endmodule // mpp_mac_end

//--- rtl/mpp_mii_if.sv
// Interface joining the port's device end and the controller end
`timescale 1ns/1ps
interface mpp_mii_if;
	logic [3:0] mac_tx_nibble;
	logic mac_tx_valid;
	logic mac_tx_fault_in;
	logic phy_tx_clock;
	logic [3:0] phy_rx_nibble;
	logic phy_rx_valid;
	logic phy_rx_fault;
	logic phy_rx_clock;
	logic collision_flag;
	logic carrier_sense_flag;
	logic mgmt_serial_clock;
	logic mdio_mac_o;
	logic mdio_mac_oe;
	logic mdio_phy_o;
	logic mdio_phy_oe;
	wire mgmt_serial_data_io;

	// Resolved wire level; the pull-up holds it high when nobody drives
	assign mgmt_serial_data_io = mdio_mac_oe ? mdio_mac_o : (mdio_phy_oe ? mdio_phy_o : 1'b1);

	modport phy (
		input mac_tx_nibble, mac_tx_valid, mac_tx_fault_in, mgmt_serial_clock,
		input mgmt_serial_data_io,
		output phy_tx_clock, phy_rx_nibble, phy_rx_valid, phy_rx_fault, phy_rx_clock,
		output collision_flag, carrier_sense_flag, mdio_phy_o, mdio_phy_oe
	);
	modport mac (
		output mac_tx_nibble, mac_tx_valid, mac_tx_fault_in, mgmt_serial_clock,
		output mdio_mac_o, mdio_mac_oe,
		input phy_tx_clock, phy_rx_nibble, phy_rx_valid, phy_rx_fault, phy_rx_clock,
		input collision_flag, carrier_sense_flag, mgmt_serial_data_io
	);
endinterface // mpp_mii_if

//--- rtl/mpp_phy_end.sv
// Device end of the port: sources both interface clocks and moves nibbles
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps

// Notes on behaviour
// - Controller changes nibble on clock, bit0 LSB
// - Normal mode samples only four data bits
// - Controller enables transmit with each nibble
// - Transmit fault meaningful only at 100 Mbps
// - Fault at 100 Mbps sends error code-groups
// - Symbol mode uses fault as fifth bit
// - Device makes transmit clock, both speeds
// - Device makes receive clock, both speeds
// - Receive nibbles driven with receive clock
// - Receive valid marks exactly valid nibbles
// - Receive fault flags bad symbols, symbol bit
// - Collision high for whole collision, unsynchronised
// - Collision always low in full duplex
// - Half duplex carrier on transmit or receive
// - Full duplex carrier on receive only
// - Strap high: management off, pins set bits
// - Strap low: pins give defaults, management after
// - Management clock no faster than 20 MHz
module mpp_phy_end
	import mpp_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	mpp_mii_if.phy mii,
	input wire logic [CFG_W-1:0] hw_cfg_i,
	input wire logic mgmt_port_disable_strap_i,
	input wire logic mgmt_wr_i,
	input wire logic [CFG_W-1:0] mgmt_wdata_i,
	input wire logic line_rx_valid_i,
	input wire logic [4:0] line_rx_symbol_i,
	input wire logic line_rx_invalid_i,
	input wire logic line_rx_active_i,
	input wire logic line_collision_i,
	output logic line_tx_valid_o,
	output logic [4:0] line_tx_symbol_o,
	output logic line_tx_halt_o,
	output logic [CFG_W-1:0] cfg_o,
	output logic mgmt_enabled_o
);
	// Controller pins pass two flops before use
	logic [XW-1:0] tx_meta_ff;
	logic [XW-1:0] tx_sync_ff;
	// Configuration capture after reset
	logic captured_ff;
	logic mgmt_en_ff;
	logic [CFG_W-1:0] cfg_ff;
	// Clock divider and interface clocks
	logic [DIV_W-1:0] div_ff;
	logic tx_clk_ff;
	logic rx_clk_ff;
	// Line side transmit
	logic tx_valid_ff;
	logic [4:0] tx_sym_ff;
	logic tx_halt_ff;
	// Receive side toward the controller
	logic [3:0] rx_nib_ff;
	logic rx_valid_ff;
	logic rx_fault_ff;
	logic col_ff;
	logic crs_ff;

	// Named decodes of configuration and synchronised pins
	wire speed_100 = cfg_ff[CFG_SPEED_BIT];
	wire full_duplex = cfg_ff[CFG_DUPLEX_BIT];
	wire symbol_mode = cfg_ff[CFG_SYMBOL_BIT];
	wire [3:0] tx_nib_s = tx_sync_ff[3:0];
	wire tx_fault_s = tx_sync_ff[TXF_FAULT_BIT];
	wire tx_en_s = tx_sync_ff[TXF_EN_BIT];
	wire [DIV_W-1:0] half_c = speed_100 ? HALF_100_C : HALF_10_C;
	// Divider waits for the capture so the first period already has the right speed
	wire div_end = captured_ff & (div_ff == DIV_RST);
	wire clk_rise = div_end & ~tx_clk_ff;
	wire clk_fall = div_end & tx_clk_ff;
	// Writes over the management channel only while it is enabled
	wire mgmt_take = mgmt_en_ff & mgmt_wr_i;

	// Two-flop synchroniser on the controller's transmit pins
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_meta_ff <= '0;
			tx_sync_ff <= '0;
		end else begin
			tx_meta_ff <= {mii.mac_tx_valid, mii.mac_tx_fault_in, mii.mac_tx_nibble};
			tx_sync_ff <= tx_meta_ff;
		end
	end

	// Strap and pins are caught at the first edge after reset release;
	// a constant reset value keeps the flops free of port values under reset.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			captured_ff <= 1'b0;
			mgmt_en_ff <= 1'b0;
			cfg_ff <= CFG_RST;
		end else if (!captured_ff) begin
			captured_ff <= 1'b1;
			mgmt_en_ff <= ~mgmt_port_disable_strap_i;
			cfg_ff <= hw_cfg_i;
		end else if (mgmt_take) begin
			cfg_ff <= mgmt_wdata_i;
		end
	end

	// One divider makes both interface clocks; speed picks the half period
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_ff <= DIV_RST;
			tx_clk_ff <= 1'b0;
			rx_clk_ff <= 1'b0;
		end else if (div_end) begin
			div_ff <= half_c;
			tx_clk_ff <= ~tx_clk_ff;
			rx_clk_ff <= ~rx_clk_ff;
		end else if (captured_ff) begin
			div_ff <= div_ff - 4'h1;
		end
	end

	// Transmit nibble taken at the rising interface clock edge
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_valid_ff <= 1'b0;
			tx_sym_ff <= 5'h00;
			tx_halt_ff <= 1'b0;
		end else if (clk_rise) begin
			if (tx_en_s) begin
				tx_valid_ff <= 1'b1;
				if (symbol_mode) begin
					tx_sym_ff <= {tx_fault_s, tx_nib_s};
					tx_halt_ff <= 1'b0;
				end else begin
					tx_sym_ff <= {1'b0, tx_nib_s};
					tx_halt_ff <= speed_100 & tx_fault_s;
				end
			end else begin
				tx_valid_ff <= 1'b0;
				tx_sym_ff <= 5'h00;
				tx_halt_ff <= 1'b0;
			end
		end
	end

	// Receive outputs change at the falling edge so the controller samples
	// them mid-period on the rising edge.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_nib_ff <= 4'h0;
			rx_valid_ff <= 1'b0;
			rx_fault_ff <= 1'b0;
		end else if (clk_fall) begin
			rx_valid_ff <= line_rx_valid_i;
			rx_nib_ff <= line_rx_valid_i ? line_rx_symbol_i[3:0] : 4'h0;
			if (symbol_mode) begin
				rx_fault_ff <= line_rx_symbol_i[4];
			end else begin
				rx_fault_ff <= line_rx_invalid_i;
			end
		end
	end

	// Collision and carrier do not wait for the interface clock
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			col_ff <= 1'b0;
			crs_ff <= 1'b0;
		end else begin
			col_ff <= line_collision_i & ~full_duplex;
			if (full_duplex) begin
				crs_ff <= line_rx_active_i;
			end else begin
				crs_ff <= line_rx_active_i | tx_en_s;
			end
		end
	end

	// Interface outputs come straight from flops
	assign mii.phy_tx_clock = tx_clk_ff;
	assign mii.phy_rx_clock = rx_clk_ff;
	assign mii.phy_rx_nibble = rx_nib_ff;
	assign mii.phy_rx_valid = rx_valid_ff;
	assign mii.phy_rx_fault = rx_fault_ff;
	assign mii.collision_flag = col_ff;
	assign mii.carrier_sense_flag = crs_ff;
	// Management answers are not modelled here; the pin is never driven
	assign mii.mdio_phy_o = 1'b0;
	assign mii.mdio_phy_oe = 1'b0;

	// User side outputs
	assign line_tx_valid_o = tx_valid_ff;
	assign line_tx_symbol_o = tx_sym_ff;
	assign line_tx_halt_o = tx_halt_ff;
	assign cfg_o = cfg_ff;
	assign mgmt_enabled_o = mgmt_en_ff;
endmodule // mpp_phy_end

//--- rtl/mpp_pkg.sv
// Shared constants for the media independent interface port, both ends
package mpp_pkg;
	// Master clock and link clock rates
	localparam int MCLK_HZ = 40_000_000;
	localparam int LINK_HZ_10 = 2_500_000;
	localparam int LINK_HZ_100 = 25_000_000;
	localparam int MDC_MAX_HZ = 20_000_000;

	// Half periods in master clocks; a longest time rounds down, never below one
	localparam int HALF_10_N = MCLK_HZ / (2 * LINK_HZ_10);
	localparam int HALF_100_RAW = MCLK_HZ / (2 * LINK_HZ_100);
	localparam int HALF_100_N = (HALF_100_RAW < 1) ? 1 : HALF_100_RAW;
	// Management clock is a least period, so round up
	localparam int MDC_HALF_N = (MCLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);

	localparam int DIV_W = 4;
	localparam logic [DIV_W-1:0] HALF_10_C = DIV_W'(HALF_10_N - 1);
	localparam logic [DIV_W-1:0] HALF_100_C = DIV_W'(HALF_100_N - 1);
	localparam logic [DIV_W-1:0] MDC_HALF_C = DIV_W'(MDC_HALF_N - 1);
	localparam logic [DIV_W-1:0] DIV_RST = 4'h0;

	// Configuration bits owned by the hardware pins or the management channel
	localparam int CFG_W = 3;
	localparam int CFG_SPEED_BIT = 0;
	localparam int CFG_DUPLEX_BIT = 1;
	localparam int CFG_SYMBOL_BIT = 2;
	localparam logic [CFG_W-1:0] CFG_RST = 3'h0;

	// Controller register map
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] REG_TX = 5'h00;
	localparam logic [ADDR_W-1:0] REG_RX = 5'h04;
	localparam logic [ADDR_W-1:0] REG_STAT = 5'h08;
	localparam logic [ADDR_W-1:0] REG_ISTAT = 5'h0C;
	localparam logic [ADDR_W-1:0] REG_IMASK = 5'h10;

	// Transmit and receive word layout: nibble 3:0, fault 4, enable/valid 5
	localparam int TXF_FAULT_BIT = 4;
	localparam int TXF_EN_BIT = 5;
	localparam int XW = 6;

	// Status register bits
	localparam int ST_TXPEND_BIT = 0;
	localparam int ST_CRS_BIT = 1;
	localparam int ST_COL_BIT = 2;

	// Interrupt bits
	localparam int IRQ_W = 4;
	localparam int IRQ_RX_BIT = 0;
	localparam int IRQ_RXERR_BIT = 1;
	localparam int IRQ_COL_BIT = 2;
	localparam int IRQ_CRS_BIT = 3;
	localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
endpackage

//--- verification/mii_port_phy_side_tb.sv
// Self-checking bench driving both ends of the port through their user sides
`timescale 1ns/1ps
module mii_port_phy_side_tb
	import mpp_pkg::*;
;
	logic mclk = 1'h0, rst_n = 1'h0, strap = 1'h0, mg_wr = 1'h0, wr = 1'h0, rd = 1'h0;
	logic lrx_valid = 1'h0, lrx_inv = 1'h0, lrx_act = 1'h0, lcol = 1'h0;
	logic [CFG_W-1:0] hw_cfg = 3'h0, mg_wdata = 3'h0, cfg;
	logic [4:0] lrx_sym = 5'h00, ltx_sym;
	logic [ADDR_W-1:0] addr = 5'h00;
	logic [31:0] wdata = 32'h0, rdata, seed = 32'h49A5;
	logic ltx_valid, ltx_halt, mg_en, irq;
	int failures = 0, tests_run = 0;
	mpp_mii_if mii ();
	mpp_phy_end mpp_phy_end_i (.mclk_i(mclk), .rst_n_i(rst_n), .mii(mii.phy), .hw_cfg_i(hw_cfg),
		.mgmt_port_disable_strap_i(strap), .mgmt_wr_i(mg_wr), .mgmt_wdata_i(mg_wdata),
		.line_rx_valid_i(lrx_valid), .line_rx_symbol_i(lrx_sym), .line_rx_invalid_i(lrx_inv),
		.line_rx_active_i(lrx_act), .line_collision_i(lcol), .line_tx_valid_o(ltx_valid),
		.line_tx_symbol_o(ltx_sym), .line_tx_halt_o(ltx_halt), .cfg_o(cfg), .mgmt_enabled_o(mg_en));
	mpp_mac_end mpp_mac_end_i (.mclk_i(mclk), .rst_n_i(rst_n), .mii(mii.mac), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq));
	mpp_sva mpp_sva_i (.mclk_i(mclk), .rst_n_i(rst_n), .cfg_o(cfg),
		.mac_tx_nibble(mii.mac_tx_nibble), .mac_tx_valid(mii.mac_tx_valid),
		.mac_tx_fault_in(mii.mac_tx_fault_in), .phy_tx_clock(mii.phy_tx_clock),
		.phy_rx_clock(mii.phy_rx_clock), .phy_rx_nibble(mii.phy_rx_nibble),
		.phy_rx_valid(mii.phy_rx_valid), .phy_rx_fault(mii.phy_rx_fault),
		.collision_flag(mii.collision_flag), .carrier_sense_flag(mii.carrier_sense_flag),
		.mgmt_serial_clock(mii.mgmt_serial_clock));

	// 40 MHz master clock
	initial begin
		forever #12.5 mclk = ~mclk;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Expected line word {valid, halt, symbol}; fault counts only at 100 Mbps or as fifth bit
	function automatic logic [6:0] exp_tx(input logic [5:0] w);
		if (!w[TXF_EN_BIT])
			return 7'h00;
		return {1'h1, hw_cfg[CFG_SPEED_BIT] & ~hw_cfg[CFG_SYMBOL_BIT] & w[4],
			hw_cfg[CFG_SYMBOL_BIT] & w[4], w[3:0]};
	endfunction
	function automatic logic [5:0] exp_rx(input logic [4:0] s, input logic inv);
		return {1'h1, hw_cfg[CFG_SYMBOL_BIT] ? s[4] : inv, s[3:0]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		if (failures == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge mclk);
		wr <= 1'h0;
	endtask
	task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		@(posedge mclk);
		addr <= a;
		rd <= 1'h1;
		@(posedge mclk);
		rd <= 1'h0;
		#1 chk(rdata, exp);
	endtask
	task automatic do_reset(input logic s, input logic [CFG_W-1:0] c);
		@(posedge mclk);
		rst_n <= 1'h0;
		strap <= s;
		hw_cfg <= c;
		repeat (6) @(posedge mclk);
		rst_n <= 1'h1;
		repeat (3) @(posedge mclk);
	endtask
	task automatic mg_write(input logic [CFG_W-1:0] d);
		@(posedge mclk);
		mg_wr <= 1'h1;
		mg_wdata <= d;
		@(posedge mclk);
		mg_wr <= 1'h0;
		repeat (2) @(posedge mclk);
	endtask
	// Bounded wait for the word on the pins, then for the device's next sampling edge
	task automatic tx_word(input logic [5:0] w);
		int n = 0;
		reg_wr(REG_TX, 32'(w));
		#1;
		while ({mii.mac_tx_valid, mii.mac_tx_fault_in, mii.mac_tx_nibble} !== w && n < 60) begin
			@(posedge mclk);
			#1;
			n++;
		end
		repeat (hw_cfg[CFG_SPEED_BIT] ? 2 * HALF_100_N + 2 : 2 * HALF_10_N - 2) @(posedge mclk);
		#1 chk(32'({ltx_valid, ltx_halt, ltx_sym}), 32'(exp_tx(w)));
	endtask
	// Line input is held for 40 master clocks, two and a half link clock periods at 10 Mbps, before looking
	task automatic rx_word(input logic v, input logic [4:0] s, input logic inv);
		@(posedge mclk);
		lrx_valid <= v;
		lrx_sym <= s;
		lrx_inv <= inv;
		repeat (40) @(posedge mclk);
		#1 chk(32'(mii.phy_rx_valid), 32'(v));
		if (v) begin
			chk(32'({mii.phy_rx_fault, mii.phy_rx_nibble}), 32'(exp_rx(s, inv) & 6'h1F));
			reg_rd(REG_RX, 32'(exp_rx(s, inv)));
		end
	endtask
	task automatic tx_period(input int exp);
		time t0;
		@(posedge mii.phy_tx_clock);
		t0 = $time;
		@(posedge mii.phy_tx_clock);
		chk(32'(($time - t0) / 25), 32'(exp));
	endtask
	task automatic col_crs(input logic full);
		do_reset(1'h0, {1'h0, full, 1'h0});
		lcol <= 1'h1;
		lrx_act <= 1'h1;
		repeat (20) @(posedge mclk);
		#1 chk(32'(mii.collision_flag), 32'(!full));
		chk(32'(mii.carrier_sense_flag), 32'h1);
		reg_rd(REG_STAT, 32'({!full, 2'h2}));
		reg_rd(REG_ISTAT, 32'({1'h1, !full, lrx_inv, lrx_valid}));
		@(posedge mclk);
		lcol <= 1'h0;
		lrx_act <= 1'h0;
		reg_wr(REG_TX, 32'h20);
		#1;
		// Carrier is looked at while the sent enable still stands on the pins
		for (int n = 0; n < 40 && !mii.mac_tx_valid; n++) begin
			@(posedge mclk);
			#1;
		end
		repeat (4) @(posedge mclk);
		#1 chk(32'(mii.collision_flag), 32'h0);
		chk(32'(mii.carrier_sense_flag), 32'(!full));
	endtask

	// Main sequence
	initial begin
		do_reset(1'h0, 3'h0);
		chk(32'({mg_en, cfg}), 32'h8);
		mg_write(3'h2);
		chk(32'(cfg), 32'h2);
		do_reset(1'h1, 3'h0);
		mg_write(3'h2);
		chk(32'({mg_en, cfg}), 32'h0);
		reg_rd(5'h14, 32'h0);
		tx_period(2 * HALF_10_N);
		reg_wr(REG_IMASK, 32'h1);
		rx_word(1'h1, 5'(rnd()), 1'h0);
		rx_word(1'h0, 5'h00, 1'h0);
		reg_rd(REG_ISTAT, 32'h1);
		chk(32'(irq), 32'h1);
		reg_wr(REG_IMASK, 32'h0);
		@(posedge mclk);
		#1 chk(32'(irq), 32'h0);
		reg_wr(REG_ISTAT, 32'h1);
		reg_rd(REG_ISTAT, 32'h0);
		for (int m = 0; m < 2; m++) begin
			do_reset(1'h0, m ? 3'h4 : 3'h0);
			repeat (8) tx_word({1'h1, 5'(rnd())});
			tx_word(6'h1F);
			repeat (6) rx_word(1'h1, 5'(rnd()), 1'(rnd()));
		end
		do_reset(1'h0, 3'h1);
		tx_period(2 * HALF_100_N);
		tx_word(6'h3A);
		tx_word(6'h2A);
		col_crs(1'h0);
		col_crs(1'h1);
		test_done();
	end

	// Watchdog: the whole sequence needs well under 10,000 master clocks
	initial begin
		#1_000_000;
		failures++;
		test_done();
	end
endmodule // mii_port_phy_side_tb

//--- verification/mpp_sva.sv
// Concurrent checks on the signals between the port's two ends
`timescale 1ns/1ps
module mpp_sva
	import mpp_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic [CFG_W-1:0] cfg_o,
	input wire logic [3:0] mac_tx_nibble,
	input wire logic mac_tx_valid,
	input wire logic mac_tx_fault_in,
	input wire logic phy_tx_clock,
	input wire logic phy_rx_clock,
	input wire logic [3:0] phy_rx_nibble,
	input wire logic phy_rx_valid,
	input wire logic phy_rx_fault,
	input wire logic collision_flag,
	input wire logic carrier_sense_flag,
	input wire logic mgmt_serial_clock
);
	default clocking dcb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	// Link clock high phase is eight master clocks slow, one fast
	a_tx_clock_slow: assert property ($rose(phy_tx_clock) && !cfg_o[CFG_SPEED_BIT] |=>
		$stable(phy_tx_clock) [*7] ##1 $fell(phy_tx_clock)) else $error("slow high phase");
	a_tx_clock_fast: assert property ($rose(phy_tx_clock) && cfg_o[CFG_SPEED_BIT] |=>
		$fell(phy_tx_clock)) else $error("fast high phase");
	a_rx_clock_same: assert property (phy_rx_clock == phy_tx_clock)
		else $error("receive clock differs");
	// Receive outputs move only with the falling receive clock
	a_rx_on_fall: assert property (!$fell(phy_rx_clock) |->
		$stable({phy_rx_nibble, phy_rx_valid, phy_rx_fault})) else $error("rx moved off clock");
	// Past value guards the cycle in which the mode itself changes
	a_col_full_quiet: assert property (cfg_o[CFG_DUPLEX_BIT] && $past(cfg_o[CFG_DUPLEX_BIT]) |->
		!collision_flag) else $error("collision in full duplex");
	// Controller pins move three clocks after a link clock rise
	a_tx_pin_launch: assert property (!cfg_o[CFG_SPEED_BIT] &&
		$changed({mac_tx_nibble, mac_tx_valid, mac_tx_fault_in}) |->
		$past(phy_tx_clock, 3) && !$past(phy_tx_clock, 4)) else $error("tx pins off clock");
	a_mgmt_clock_rate: assert property (mgmt_serial_clock |=> !mgmt_serial_clock)
		else $error("management clock too slow or fast");
	a_crs_half_tx: assert property (mac_tx_valid [*4] ##0 !cfg_o[CFG_DUPLEX_BIT] |->
		carrier_sense_flag) else $error("no carrier while sending");
endmodule // mpp_sva
